// ---- verilog/rsc_pkg.sv ----
// reset_source_control package: register map, cause bit layout, timing constants
// assumes a single 25 MHz system clock and a byte-wide register port
// Behaviour
// RQ1: flash error reset sets bit 6
// RQ2: bit 5 write enables low-active comparator reset
// RQ3: bit 5 reads one after comparator reset
// RQ4: writing one to bit 4 forces reset
// RQ5: bit 4 reads one after software reset
// RQ6: watchdog overflow reset sets bit 3
// RQ7: bit 2 write enables missing-clock reset
// RQ8: bit 2 reads one after missing-clock reset
// RQ9: bit 1 write enables supply monitor reset
// RQ10: software enables bit 1 only once settled
// RQ11: power or supply reset sets bit 1
// RQ12: external pin reset sets bit 0
// RQ13: software writes whole bytes, never read-modify-write
// RQ14: read-only and unused bit writes ignored
package rsc_pkg;
	// register port
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_CAUSE_EN = 4'h0;
	localparam int DATA_W = 8;

	// bit positions in reset_cause_and_enable
	localparam int BIT_UNUSED = 7;
	localparam int BIT_FLASH = 6;
	localparam int BIT_CMP = 5;
	localparam int BIT_SW = 4;
	localparam int BIT_WDT = 3;
	localparam int BIT_MCD = 2;
	localparam int BIT_PWR = 1;
	localparam int BIT_PIN = 0;
	localparam int NCAUSE = 7;

	// flag value after power-on: only the power flag stands
	localparam logic [NCAUSE-1:0] FLAGS_POR = 7'h02;
	localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;

	// system reset hold time after a trigger
	localparam int CLK_PERIOD_NS = 40;
	localparam int HOLD_NS = 400;
	localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_W = 8;

	// sequencer states, one-hot
	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_HOLD = 2'b10
	} rsc_state_t;
endpackage : rsc_pkg

// ---- verilog/rsc_cause_latch.sv ----
// rsc_cause_latch: holds the reset-cause flags across system resets
// assumes only the power-on reset clears it; capture is a one-cycle pulse
`timescale 1ns/1ps
module rsc_cause_latch #(
	parameter int W = 7
) (
	// clock and power-on reset
	input wire logic clk,
	input wire logic rst_n,
	// capture of a new cause vector
	input wire logic capture,
	input wire logic [W-1:0] causes,
	// latched flags
	output logic [W-1:0] flags
);
	logic [W-1:0] flags_d;
	logic [W-1:0] flags_q;

	// a new reset replaces the old cause completely, so there is no clear path
	always_comb begin
		flags_d = flags_q;
		if (capture) begin
			flags_d = causes;
		end
	end

	// power-on leaves only the power flag set
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags_q <= rsc_pkg::FLAGS_POR;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign flags = flags_q;
endmodule : rsc_cause_latch

// ---- verilog/rsc_hold_timer.sv ----
// rsc_hold_timer: counts the length of the system reset pulse
// assumes start arrives only while idle; extend keeps the count at its top
`timescale 1ns/1ps
module rsc_hold_timer #(
	parameter int CNT_W = 8,
	parameter int HOLD = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic start,
	input wire logic extend,
	// status
	output logic busy,
	output logic done
);
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] cnt_q;

	// load on start, reload while extended, count down otherwise
	always_comb begin
		cnt_d = cnt_q;
		if (start || (extend && cnt_q != '0)) begin
			cnt_d = CNT_W'(HOLD);
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	// power-on preloads a full hold so the sequencer leaves its reset state by itself
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= CNT_W'(HOLD);
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign busy = (cnt_q != '0);
	// last cycle of the hold, unless still extended
	assign done = (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) && !extend;
endmodule : rsc_hold_timer

// ---- verilog/rsc_top.sv ----
// rsc_top: reset-source register, reset sequencer and cause recording
// assumes RSTN is the power-on reset and all source inputs are synchronous
// to MCLK; SYS_RST_N drives the reset of the rest of the device
`timescale 1ns/1ps
module rsc_top #(
	parameter int HOLD_CYCLES = rsc_pkg::HOLD_CYC
) (
	// clock and power-on reset
	input wire logic MCLK,
	input wire logic RSTN,
	// register port
	input wire logic [rsc_pkg::ADDR_W-1:0] ADDR,
	input wire logic [rsc_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [rsc_pkg::DATA_W-1:0] RDATA,
	// reset sources
	input wire logic FLASH_ERR,
	input wire logic CMP_OUT,
	input wire logic WDT_OVF,
	input wire logic CLK_MISSING,
	input wire logic VDD_LOW,
	input wire logic PIN_RST_N,
	// system reset and source enables
	output logic SYS_RST_N,
	output logic CMP_RST_EN,
	output logic MCD_EN,
	output logic VDDMON_EN
);
	rsc_pkg::rsc_state_t state_d;
	rsc_pkg::rsc_state_t state_q;
	logic cmp_en_d;
	logic cmp_en_q;
	logic mcd_en_d;
	logic mcd_en_q;
	logic vdd_en_d;
	logic vdd_en_q;
	logic [rsc_pkg::DATA_W-1:0] rdata_d;
	logic [rsc_pkg::DATA_W-1:0] rdata_q;
	logic sys_rst_n_d;
	logic sys_rst_n_q;
	logic [rsc_pkg::NCAUSE-1:0] causes;
	logic [rsc_pkg::NCAUSE-1:0] flags;
	logic run;
	logic hit;
	logic wr_hit;
	logic sw_force;
	logic supply_rst;
	logic trigger;
	logic hold_busy;
	logic hold_done;

	// single register decode, reused by read and write paths
	function automatic logic reg_hit(input logic [rsc_pkg::ADDR_W-1:0] a);
		reg_hit = (a == rsc_pkg::OFS_CAUSE_EN);
	endfunction : reg_hit

	assign run = (state_q == rsc_pkg::ST_RUN);
	assign hit = reg_hit(ADDR);
	// writes are ignored while the device is held in reset
	assign wr_hit = WR && hit && run;
	assign sw_force = wr_hit && WDATA[rsc_pkg::BIT_SW]; // RQ4

	// supply reset dominates; with it the other causes carry no meaning
	assign supply_rst = vdd_en_q && VDD_LOW; // RQ9

	// cause vector seen this cycle
	always_comb begin
		causes = '0;
		if (supply_rst) begin
			causes[rsc_pkg::BIT_PWR] = 1'b1; // RQ11
		end else begin
			causes[rsc_pkg::BIT_FLASH] = FLASH_ERR; // RQ1
			causes[rsc_pkg::BIT_CMP] = cmp_en_q && !CMP_OUT; // RQ2 RQ3
			causes[rsc_pkg::BIT_SW] = sw_force; // RQ5
			causes[rsc_pkg::BIT_WDT] = WDT_OVF; // RQ6
			causes[rsc_pkg::BIT_MCD] = mcd_en_q && CLK_MISSING; // RQ7 RQ8
			causes[rsc_pkg::BIT_PIN] = !PIN_RST_N; // RQ12
		end
	end

	// only a running device can be reset anew; in hold the cause is frozen
	assign trigger = run && (causes != '0);

	// cause flags survive system resets, only power-on clears them
	rsc_cause_latch #(
		.W(rsc_pkg::NCAUSE)
	) u_latch (
		.clk(MCLK),
		.rst_n(RSTN),
		.capture(trigger),
		.causes(causes),
		.flags(flags)
	);

	// a held pin or low supply keeps the device in reset until released
	rsc_hold_timer #(
		.CNT_W(rsc_pkg::HOLD_W),
		.HOLD(HOLD_CYCLES)
	) u_hold (
		.clk(MCLK),
		.rst_n(RSTN),
		.start(trigger),
		.extend(!PIN_RST_N || supply_rst),
		.busy(hold_busy),
		.done(hold_done)
	);

	// sequencer: run until a trigger, then hold the system in reset
	always_comb begin
		state_d = state_q;
		case (state_q)
			rsc_pkg::ST_RUN: begin
				if (trigger) begin
					state_d = rsc_pkg::ST_HOLD;
				end
			end
			rsc_pkg::ST_HOLD: begin
				if (hold_done) begin
					state_d = rsc_pkg::ST_RUN;
				end
			end
			default: begin
				state_d = rsc_pkg::ST_HOLD;
			end
		endcase
	end

	// system reset low from the edge after the trigger until hold ends
	always_comb begin
		sys_rst_n_d = (state_d == rsc_pkg::ST_RUN);
	end

	// enables: a system reset returns comparator and clock detector to off,
	// the supply monitor enable stays so the device keeps its brown-out guard
	always_comb begin
		cmp_en_d = cmp_en_q;
		mcd_en_d = mcd_en_q;
		vdd_en_d = vdd_en_q;
		if (trigger) begin
			cmp_en_d = 1'b0;
			mcd_en_d = 1'b0;
		end else if (wr_hit) begin
			// whole-byte write; flash, watchdog, pin and top bits are dropped
			cmp_en_d = WDATA[rsc_pkg::BIT_CMP]; // RQ2 RQ14
			mcd_en_d = WDATA[rsc_pkg::BIT_MCD]; // RQ7 RQ13
			// software must not set this before the monitor has settled
			vdd_en_d = WDATA[rsc_pkg::BIT_PWR]; // RQ9 RQ10
		end
	end

	// read data: flags in low bits, unused top bit reads zero
	always_comb begin
		rdata_d = rsc_pkg::RDATA_RST;
		if (RD && hit) begin
			rdata_d = {1'b0, flags}; // RQ3 RQ5 RQ8 RQ14
		end
	end

	// one register stage for all state of this module
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			state_q <= rsc_pkg::ST_HOLD;
			cmp_en_q <= 1'b0;
			mcd_en_q <= 1'b0;
			vdd_en_q <= 1'b0;
			rdata_q <= rsc_pkg::RDATA_RST;
			sys_rst_n_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cmp_en_q <= cmp_en_d;
			mcd_en_q <= mcd_en_d;
			vdd_en_q <= vdd_en_d;
			rdata_q <= rdata_d;
			sys_rst_n_q <= sys_rst_n_d;
		end
	end

	// the power-on hold ends when the preloaded timer runs out
	assign RDATA = rdata_q;
	assign SYS_RST_N = sys_rst_n_q;
	assign CMP_RST_EN = cmp_en_q;
	assign MCD_EN = mcd_en_q;
	assign VDDMON_EN = vdd_en_q;

	// flash error in a running device is recorded in bit 6
	a_flash_flag: assert property (@(posedge MCLK) disable iff (!RSTN) // RQ1
		run && FLASH_ERR && !supply_rst |=> flags[rsc_pkg::BIT_FLASH] && !SYS_RST_N)
		else $error("flash error not recorded");

	// a written comparator enable arms the comparator source
	a_cmp_enable: assert property (@(posedge MCLK) disable iff (!RSTN) // RQ2
		wr_hit && WDATA[5] && !trigger |=> CMP_RST_EN)
		else $error("comparator enable not taken");

	// comparator low while armed resets and is read back as bit 5
	a_cmp_flag: assert property (@(posedge MCLK) disable iff (!RSTN) // RQ3
		run && cmp_en_q && !CMP_OUT && !supply_rst
		|=> flags[rsc_pkg::BIT_CMP] && !CMP_RST_EN)
		else $error("comparator reset not recorded");

	// software force holds system reset low for at least 8 cycles
	a_sw_force: assert property (@(posedge MCLK) disable iff (!RSTN) // RQ4
		sw_force |=> !SYS_RST_N [*8])
		else $error("software reset not forced");

	// after a forced reset, a read returns bit 4 set
	a_sw_readback: assert property (@(posedge MCLK) disable iff (!RSTN) // RQ5
		sw_force && !supply_rst ##1 (RD && hit) |=> RDATA[4])
		else $error("software flag not read back");

	// watchdog overflow recorded in bit 3
	a_wdt_flag: assert property (@(posedge MCLK) disable iff (!RSTN) // RQ6
		run && WDT_OVF && !supply_rst |=> flags[rsc_pkg::BIT_WDT])
		else $error("watchdog reset not recorded");

	// missing clock ignored unless enabled
	a_mcd_gate: assert property (@(posedge MCLK) disable iff (!RSTN) // RQ7
		run && CLK_MISSING && !mcd_en_q && (causes == '0) |=> SYS_RST_N)
		else $error("missing clock reset while disabled");

	// missing clock with enable recorded in bit 2
	a_mcd_flag: assert property (@(posedge MCLK) disable iff (!RSTN) // RQ8
		run && CLK_MISSING && mcd_en_q && !supply_rst
		|=> flags[rsc_pkg::BIT_MCD] && !MCD_EN)
		else $error("missing clock reset not recorded");

	// supply monitor survives a system reset once enabled
	a_vdd_keep: assert property (@(posedge MCLK) disable iff (!RSTN) // RQ9
		vdd_en_q && trigger |=> VDDMON_EN)
		else $error("supply monitor enable lost");

	// supply reset leaves only the power flag
	a_pwr_only: assert property (@(posedge MCLK) disable iff (!RSTN) // RQ11
		run && supply_rst |=> flags == rsc_pkg::FLAGS_POR)
		else $error("supply reset flags wrong");

	// pin low in a running device is recorded in bit 0 and holds reset
	a_pin_flag: assert property (@(posedge MCLK) disable iff (!RSTN) // RQ12
		run && !PIN_RST_N && !supply_rst |=> flags[0] && !SYS_RST_N)
		else $error("pin reset not recorded");

	// writes that start no reset leave the flags unchanged
	a_ro_bits: assert property (@(posedge MCLK) disable iff (!RSTN) // RQ14
		wr_hit && !trigger |=> $stable(flags))
		else $error("write changed read-only flags");

	// unused bit always reads zero
	a_unused_zero: assert property (@(posedge MCLK) disable iff (!RSTN) // RQ14
		RD && hit |=> !RDATA[7] && (RDATA[6:0] == $past(flags)))
		else $error("read data wrong");

	// hold ends within 300 cycles once sources are gone
	a_hold_end: assert property (@(posedge MCLK) disable iff (!RSTN) // RQ4
		!run && PIN_RST_N && !supply_rst && hold_busy ##1 (PIN_RST_N && !supply_rst) [*1]
		|-> ##[0:300] SYS_RST_N || !PIN_RST_N || supply_rst)
		else $error("system reset never released");
endmodule : rsc_top

// ---- sim/reset_source_control_tb_top.sv ----
// reset_source_control_tb_top: self-checking bench for the reset-source register
// assumes rsc_top at its default hold count; reads are checked from a queue of expectations
`timescale 1ns/1ps
`define RSC_CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module reset_source_control_tb_top;
	localparam int HOLD = rsc_pkg::HOLD_CYC;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic [rsc_pkg::ADDR_W-1:0] addr = 4'h0;
	logic [rsc_pkg::DATA_W-1:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [rsc_pkg::DATA_W-1:0] rdata;
	logic flash_err = 1'b0;
	logic cmp_out = 1'b1;
	logic wdt_ovf = 1'b0;
	logic clk_missing = 1'b0;
	logic vdd_low = 1'b0;
	logic pin_rst_n = 1'b1;
	logic sys_rst_n;
	logic cmp_rst_en;
	logic mcd_en;
	logic vddmon_en;
	logic [7:0] exp_q[$];
	logic [7:0] exp_v;
	logic rd_pend = 1'b0;
	int fail_count = 0;
	int n_compared = 0;
	integer seed = 10011;
	logic [31:0] r;
	// source index, enable byte written first, flag byte expected after the reset
	int src_tab[5] = '{1, 3, 4, 0, 2};
	logic [7:0] en_tab[5] = '{8'h20, 8'h04, 8'h02, 8'h00, 8'h00};
	logic [7:0] flag_tab[5] = '{8'h20, 8'h04, 8'h02, 8'h40, 8'h08};

	rsc_top #(.HOLD_CYCLES(HOLD)) u_dut (.MCLK(mclk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .FLASH_ERR(flash_err), .CMP_OUT(cmp_out),
		.WDT_OVF(wdt_ovf), .CLK_MISSING(clk_missing), .VDD_LOW(vdd_low), .PIN_RST_N(pin_rst_n),
		.SYS_RST_N(sys_rst_n), .CMP_RST_EN(cmp_rst_en), .MCD_EN(mcd_en), .VDDMON_EN(vddmon_en));

	always #20 mclk = ~mclk;

	// read data stands only in the cycle after the strobe, so look at mid-cycle
	always @(negedge mclk) begin
		if (rd_pend) begin
			exp_v = exp_q.pop_front();
			`RSC_CHK(rdata, exp_v)
		end else if (rstn) begin
			`RSC_CHK(rdata, 8'h00)
		end
		rd_pend = rd;
	end

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report

	// strobes stay up on return so back-to-back cycles never assign twice per step
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge mclk);
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		exp_q.push_back(e);
		@(posedge mclk);
	endtask : rd_reg

	task automatic idle();
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge mclk);
	endtask : idle

	// one-cycle activation of a reset source
	task automatic fire(input int src);
		case (src)
			0: flash_err <= 1'b1;
			1: cmp_out <= 1'b0;
			2: wdt_ovf <= 1'b1;
			3: clk_missing <= 1'b1;
			4: vdd_low <= 1'b1;
			default: pin_rst_n <= 1'b0;
		endcase
		@(posedge mclk);
		flash_err <= 1'b0;
		cmp_out <= 1'b1;
		wdt_ovf <= 1'b0;
		clk_missing <= 1'b0;
		vdd_low <= 1'b0;
		pin_rst_n <= 1'b1;
	endtask : fire

	// bounded wait for the end of the system reset pulse
	task automatic wait_run();
		int n;
		n = 0;
		while (sys_rst_n !== 1'b1 && n < 200) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 200) begin
			fail_count++;
			$display("unexpected at %0t: system reset stuck low", $time);
			final_report();
		end
	endtask : wait_run

	initial begin
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		rd_reg(4'h0, 8'h02);
		idle();
		// let the power-on hold end, then a pin pulse resets the running device
		wait_run();
		fire(5);
		@(posedge mclk);
		wait_run();
		rd_reg(4'h0, 8'h01);
		// random traffic to unmapped places must neither reset nor alter flags
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			wr_reg(r[3:0] | 4'h1, r[11:4]);
			rd_reg(r[3:0] | 4'h1, 8'h00);
			rd_reg(4'h0, 8'h01);
		end
		idle();
		// gated sources do nothing while their enable is clear
		foreach (src_tab[i]) begin
			if (i < 3) begin
				fire(src_tab[i]);
				@(negedge mclk);
				`RSC_CHK(sys_rst_n, 1'b1)
				@(posedge mclk);
			end
		end
		// each source in turn: enable, trigger, check the recorded cause
		foreach (src_tab[i]) begin
			wr_reg(4'h0, en_tab[i]);
			idle();
			`RSC_CHK({cmp_rst_en, mcd_en, vddmon_en}, {en_tab[i][5], en_tab[i][2], en_tab[i][1]})
			fire(src_tab[i]);
			@(negedge mclk);
			`RSC_CHK(sys_rst_n, 1'b0)
			@(posedge mclk);
			wait_run();
			rd_reg(4'h0, flag_tab[i]);
			idle();
		end
		// software reset, with an enable write landing inside the hold
		wr_reg(4'h0, 8'h10);
		wr_reg(4'h0, 8'h24);
		idle();
		`RSC_CHK({sys_rst_n, cmp_rst_en, mcd_en}, 3'b000)
		wait_run();
		rd_reg(4'h0, 8'h10);
		// read-only bits and the unused bit ignore writes
		wr_reg(4'h0, 8'hc9);
		rd_reg(4'h0, 8'h10);
		rd_reg(4'h0, 8'h10);
		idle();
		`RSC_CHK(sys_rst_n, 1'b1)
		repeat (3) @(posedge mclk);
		final_report();
	end
endmodule : reset_source_control_tb_top
